// ### bench/acs_board.sv
// Board side: clocks and pen line into acs_top.
// Assumes SYS_CLK from tb; outputs move on falling edges.
`timescale 1ns/10ps
module acs_board
(
    input logic SYS_CLK,
    input acs_pkg::acs_ctl_t CTL,
    output logic PLL_CLK,
    output logic XTAL_OSC_CLK,
    output logic MASTER_CLK_PIN,
    output logic PEN_IRQ_N
);
    logic [3:0] cnt_r = 4'h0;
    always @(negedge SYS_CLK)
        cnt_r <= cnt_r + 4'h1;
    assign {PEN_IRQ_N, XTAL_OSC_CLK, PLL_CLK} = cnt_r[2:0];
    // Grounded while the crystal stands in
    assign MASTER_CLK_PIN = CTL[1] ? 1'b0 : cnt_r[3];
endmodule // acs_board

// ### bench/acs_monitor.sv
// Checker bound to acs_top.
// Assumes inputs move on falling edges.
`timescale 1ns/10ps
module acs_monitor
(
    input logic SYS_CLK,
    input logic RST_N,
    input acs_pkg::acs_req_t REQ,
    input logic [15:0] RDATA,
    input logic PLL_CLK,
    input logic XTAL_OSC_CLK,
    input logic MASTER_CLK_PIN,
    input logic PEN_IRQ_N,
    input logic PEN_INTERRUPT_PIN,
    input logic CODEC_MCLK,
    input logic OSC_ENABLE,
    input acs_pkg::acs_ctl_t CTL
);
    import acs_pkg::*;
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_N);
    // ====
    // Checks
    wire r = REQ[24:16] == 9'h09b;
    wire o = REQ[24:16] == 9'h185;
    wire p = PEN_INTERRUPT_PIN;
    wire m = CODEC_MCLK;
    a_upper_fixed: assert property (r |=> RDATA[15:4] == 12'h040) else $error("hi");
    a_low_zero: assert property (r |=> RDATA[1:0] == 2'h0) else $error("lo");
    a_pll_pen: assert property (CTL[2] |-> p == PLL_CLK) else $error("pll");
    a_pen_normal: assert property (!CTL[2] |-> p == PEN_IRQ_N) else $error("pen");
    a_xtal_mclk: assert property (CTL[1] |-> m == (XTAL_OSC_CLK & CTL[0])) else $error("x");
    a_mclk_normal: assert property (!CTL[1] |-> m == MASTER_CLK_PIN) else $error("mck");
    a_osc_store: assert property (o |=> CTL[0] == $past(REQ[5])) else $error("osc");
    a_osc_pin: assert property (o |=> OSC_ENABLE == $past(REQ[5])) else $error("osc pin");
    c_pll: cover property (CTL[2] && PLL_CLK);
    c_xtal: cover property (CTL[1] && CTL[0]);
    c_rd: cover property (r);
endmodule // acs_monitor
bind acs_top acs_monitor u_mon (.*);

// ### bench/tb.sv
// Bench for acs_top: register port and read-back.
// Assumes the board model and the bound checker.
`timescale 1ns/10ps
module tb;
    import acs_pkg::*;
    logic SYS_CLK = 1'b0;
    logic RST_N = 1'b0;
    acs_req_t REQ = '0;
    acs_ctl_t CTL;
    logic [15:0] RDATA, q[$];
    logic PLL_CLK, XTAL_OSC_CLK, MASTER_CLK_PIN, PEN_IRQ_N, PEN_INTERRUPT_PIN;
    logic CODEC_MCLK, OSC_ENABLE, want = 1'b0, armed = 1'b0;
    logic [31:0] v, rs = 32'h136e8;
    int fail_count = 0;
    int checks = 0;
    acs_top DUT (.*);
    acs_board brd (.*);
    initial forever #20 SYS_CLK = ~SYS_CLK;
    function logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    // ====
    // Reads carry their expected word in the data field
    task acc(logic w, logic [7:0] a, logic [15:0] d);
        @(negedge SYS_CLK);
        REQ = {w, a, d};
        want = !w;
        if (!w)
            q.push_back(d);
    endtask
    always @(posedge SYS_CLK)
        armed <= want;
    always @(negedge SYS_CLK)
        if (armed)
        begin
            checks++;
            if (RDATA !== q[0])
            begin
                fail_count++;
                $display("MISMATCH %0t %h %h", $time, RDATA, q[0]);
            end
            void'(q.pop_front());
        end
    task test_done();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        #40000 fail_count++;
        test_done();
    end
    initial
    begin
        repeat (6) @(negedge SYS_CLK);
        RST_N = 1'b1;
        acc(0, 8'h9b, 16'h400);
        acc(0, 8'h85, 16'h0);
        repeat (12)
        begin
            v = rnd();
            acc(1, 8'h85, v[15:0] & 16'h20);
            acc(1, 8'h9b, v[15:0] & 16'hc | 16'h400);
            acc(0, 8'h9b, v[15:0] & 16'hc | 16'h400);
            acc(0, 8'h85, v[15:0] & 16'h20);
            acc(0, 8'h9c, 16'h0);
            repeat (8) acc(1, 8'h0, 16'h0);
        end
        test_done();
    end
endmodule // tb

// ### hw/acs_clk_mux.sv
// Clock source selection for the codec master clock and the pen-interrupt pin.
// Assumes select levels come from registers on SYS_CLK; the clocks are routed combinationally.
`timescale 1ns/10ps
module acs_clk_mux
(
    input wire logic sel,
    input wire logic in_a,
    input wire logic in_b,
    output logic out_y
);
    import acs_pkg::*;

    // Plain selection; a glitch-free switch belongs to the analog clock cell
    assign out_y = sel ? in_b : in_a;

endmodule // acs_clk_mux

// ### hw/acs_pkg.sv
// Package for the audio clock source select block: register map, fields, reset values.
// Assumes a register port that delivers page/address, write strobe and 16-bit data.
package acs_pkg;

    // ==========================================
    // Register map
    localparam logic [1:0] ACS_PAGE = 2'h2;
    localparam logic [5:0] ACS_CLK_CFG_ADDR = 6'h1b;
    localparam logic [5:0] ACS_PWR_CTRL_ADDR = 6'h05;
    localparam logic [1:0] ACS_PWR_CTRL_PAGE = 2'h2;

    // ==========================================
    // Field positions
    localparam int ACS_PLL_PEN_BIT = 3;
    localparam int ACS_XTAL_MCLK_BIT = 2;
    localparam int ACS_OSC_EN_BIT = 5;

    // ==========================================
    // Fixed read-back values and reset values
    localparam logic [11:0] ACS_UPPER_FIXED = 12'h040;
    localparam logic [1:0] ACS_LOW_FIXED = 2'h0;
    localparam logic ACS_PLL_PEN_RST = 1'b0;
    localparam logic ACS_XTAL_MCLK_RST = 1'b0;
    localparam logic ACS_OSC_EN_RST = 1'b0;

    // ==========================================
    // Register port request
    typedef struct packed {
        logic wr;
        logic [1:0] page;
        logic [5:0] addr;
        logic [15:0] wdata;
    } acs_req_t;

    // ==========================================
    // Clock source controls
    typedef struct packed {
        logic pll_to_pen_pin_select;
        logic xtal_as_master_clock;
        logic osc_enable;
    } acs_ctl_t;

endpackage

// ### hw/acs_top.sv
// Audio clock source configuration register and the clock routing it steers.
// Assumes a synchronous register port on SYS_CLK; clocks arrive as plain wires.
// How it works
// - Bits 15..4 are fixed and always read back as 040h.
// - Bit 3 set drives the audio PLL clock onto the pen-interrupt pin.
// - Bit 3 clear, the default, keeps the normal pen-interrupt function.
// - Bit 2 set uses the crystal oscillator, gated by power-control bit 5, as codec master clock.
// - Bit 2 clear, the default, leaves crystal and master clock independent.
// - Bits 1..0 are fixed and always read back as zero.
// - Power-control bit 5 turns the oscillator on; off after reset.
`timescale 1ns/10ps
module acs_top
(
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire acs_pkg::acs_req_t REQ,
    output logic [15:0] RDATA,
    input wire logic PLL_CLK,
    input wire logic XTAL_OSC_CLK,
    input wire logic MASTER_CLK_PIN,
    input wire logic PEN_IRQ_N,
    output logic PEN_INTERRUPT_PIN,
    output logic CODEC_MCLK,
    output logic OSC_ENABLE,
    output acs_pkg::acs_ctl_t CTL
);
    import acs_pkg::*;

    // ==========================================
    // Address decode
    logic hit_cfg;
    logic hit_pwr;
    logic wr_cfg;
    logic wr_pwr;
    // Same page and address match serves both registers
    function automatic logic reg_hit
    (
        input acs_req_t req,
        input logic [1:0] page,
        input logic [5:0] addr
    );
        return (req.page == page) && (req.addr == addr);
    endfunction

    assign hit_cfg = reg_hit(REQ, ACS_PAGE, ACS_CLK_CFG_ADDR);
    assign hit_pwr = reg_hit(REQ, ACS_PWR_CTRL_PAGE, ACS_PWR_CTRL_ADDR);
    assign wr_cfg = REQ.wr && hit_cfg;
    assign wr_pwr = REQ.wr && hit_pwr;

    // ==========================================
    // Control bits
    logic pll_pen_r;
    logic pll_pen_nxt;
    logic xtal_mclk_r;
    logic xtal_mclk_nxt;
    logic osc_en_r;
    logic osc_en_nxt;
    // Reserved fields are not stored; writes to them are dropped
    assign pll_pen_nxt = wr_cfg ? REQ.wdata[ACS_PLL_PEN_BIT] : pll_pen_r;
    assign xtal_mclk_nxt = wr_cfg ? REQ.wdata[ACS_XTAL_MCLK_BIT] : xtal_mclk_r;
    assign osc_en_nxt = wr_pwr ? REQ.wdata[ACS_OSC_EN_BIT] : osc_en_r;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            pll_pen_r <= ACS_PLL_PEN_RST;
            xtal_mclk_r <= ACS_XTAL_MCLK_RST;
            osc_en_r <= ACS_OSC_EN_RST;
        end
        else
        begin
            pll_pen_r <= pll_pen_nxt;
            xtal_mclk_r <= xtal_mclk_nxt;
            osc_en_r <= osc_en_nxt;
        end
    end

    // ==========================================
    // Read-back, registered
    logic [15:0] rd_mux;
    logic [15:0] rdata_r;
    logic [15:0] pwr_rd;
    assign pwr_rd = {10'h000, osc_en_r, 5'h00};
    assign rd_mux = hit_cfg ? {ACS_UPPER_FIXED, pll_pen_r, xtal_mclk_r, ACS_LOW_FIXED}
                  : hit_pwr ? pwr_rd
                  : 16'h0000;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
            rdata_r <= 16'h0000;
        else if (!REQ.wr)
            rdata_r <= rd_mux;
    end
    assign RDATA = rdata_r;

    // ==========================================
    // Clock routing
    // Stopped oscillator gives a flat master clock rather than a floating one
    logic xtal_gated;
    assign xtal_gated = XTAL_OSC_CLK & osc_en_r;

    // External pin is assumed grounded by the board while the crystal is chosen
    acs_clk_mux u_mclk_mux
    (
        .sel(xtal_mclk_r),
        .in_a(MASTER_CLK_PIN),
        .in_b(xtal_gated),
        .out_y(CODEC_MCLK)
    );

    // Pen interrupts are lost while the PLL owns the pin
    acs_clk_mux u_pen_mux
    (
        .sel(pll_pen_r),
        .in_a(PEN_IRQ_N),
        .in_b(PLL_CLK),
        .out_y(PEN_INTERRUPT_PIN)
    );

    assign OSC_ENABLE = osc_en_r;
    assign CTL = '{pll_to_pen_pin_select: pll_pen_r,
                   xtal_as_master_clock: xtal_mclk_r,
                   osc_enable: osc_en_r};

endmodule // acs_top
